// ==== design/ptf_pkg.sv ====
// Package of constants for the PHY test features block
package ptf_pkg;
   // ------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------
   localparam logic [11:0] OFF_GEN_CTRL = 12'h000;
   localparam logic [11:0] OFF_GEN_CFG = 12'h004;
   localparam logic [11:0] OFF_CU_GOOD = 12'h008;
   localparam logic [11:0] OFF_CU_BAD = 12'h00C;
   localparam logic [11:0] OFF_RX_GOOD = 12'h010;
   localparam logic [11:0] OFF_RX_SEL = 12'h014;
   localparam logic [11:0] OFF_TX_GOOD = 12'h018;
   localparam logic [11:0] OFF_TX_SEL = 12'h01C;
   localparam logic [11:0] OFF_SD_CMD = 12'h020;
   localparam logic [11:0] OFF_PHY_CTRL = 12'h024;
   // ------------------------------------------------
   // Field positions
   // ------------------------------------------------
   localparam int GEN_EN_BIT = 15;
   localparam int GEN_TX_BIT = 14;
   localparam int GEN_DUR_BIT = 13;
   localparam int FLAG_BIT = 15;
   localparam int ISO_BIT = 10;
   localparam int NEAR_BIT = 14;
   localparam int FAR_BIT = 3;
   localparam int CONN_BIT = 0;
   localparam int SWAP_BIT = 5;
   localparam int PASS_BIT = 8;
   // ------------------------------------------------
   // Values and counts
   // ------------------------------------------------
   localparam logic [13:0] GOOD_MAX = 14'h270F;
   localparam logic [7:0] BAD_MAX = 8'hFF;
   localparam logic [24:0] FRAME_LIMIT = 25'h1C9C380;
   localparam logic [3:0] SD_TAG = 4'h9;
   localparam logic [3:0] SD_TAIL = 4'h2;
   localparam logic [1:0] SEL_MEDIA = 2'h0;
   localparam logic [1:0] SEL_MAC = 2'h1;
   localparam logic [15:0] GEN_CTRL_RST = 16'h0000;
   localparam logic [2:0] SD_APPLY_CYC = 3'h4;
   // ------------------------------------------------
   // Loop types
   // ------------------------------------------------
   typedef enum logic [1:0] {
      LOOP_NONE = 2'b00,
      LOOP_INPUT = 2'b01,
      LOOP_FACILITY = 2'b10,
      LOOP_EQUIPMENT = 2'b11
   } ptf_loop_t;
endpackage : ptf_pkg

// ==== design/ptf_top.sv ====
// PHY test features: generator, frame counters, loopback controls
`timescale 1ns/1ps
`default_nettype none
module ptf_top (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Frame events at monitored points (one-cycle pulses)
   input wire logic cu_rx_frame_i,
   input wire logic cu_rx_crc_ok_i,
   input wire logic fib_rx_frame_i,
   input wire logic fib_rx_crc_ok_i,
   input wire logic mac_rx_frame_i,
   input wire logic mac_rx_crc_ok_i,
   input wire logic fib_tx_frame_i,
   input wire logic fib_tx_crc_ok_i,
   input wire logic mac_tx_frame_i,
   input wire logic mac_tx_crc_ok_i,
   // Generator handshake with the frame engine
   input wire logic gen_frame_done_i,
   output logic gen_active_o,
   output logic gen_sending_o,
   // Datapath selects
   output logic mac_tx_ignore_o,
   output logic mac_rx_enable_o,
   output logic far_loop_o,
   output logic near_loop_o,
   output logic conn_loop_o,
   output logic swap_off_o,
   // SerDes loop control
   output logic [3:0] sd_port_o,
   output logic [1:0] sd_loop_o,
   output logic sd_apply_o,
   input wire logic sd_done_i
);
   // ------------------------------------------------
   // Bus decode
   // ------------------------------------------------
   logic acc;
   logic wr;
   logic rd;
   assign acc = psel_i & penable_i;
   assign wr = acc & pwrite_i;
   assign rd = acc & ~pwrite_i;
   assign pready_o = 1'b1;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   function automatic ptf_pkg::ptf_loop_t loop_dec(input logic [3:0] t);
      case (t)
         4'h2: loop_dec = ptf_pkg::LOOP_INPUT;
         4'h4: loop_dec = ptf_pkg::LOOP_FACILITY;
         4'h8: loop_dec = ptf_pkg::LOOP_EQUIPMENT;
         default: loop_dec = ptf_pkg::LOOP_NONE;
      endcase
   endfunction : loop_dec

   logic mapped;
   assign mapped = hit(paddr_i, ptf_pkg::OFF_GEN_CTRL) | hit(paddr_i, ptf_pkg::OFF_GEN_CFG)
      | hit(paddr_i, ptf_pkg::OFF_CU_GOOD) | hit(paddr_i, ptf_pkg::OFF_CU_BAD)
      | hit(paddr_i, ptf_pkg::OFF_RX_GOOD) | hit(paddr_i, ptf_pkg::OFF_RX_SEL)
      | hit(paddr_i, ptf_pkg::OFF_TX_GOOD) | hit(paddr_i, ptf_pkg::OFF_TX_SEL)
      | hit(paddr_i, ptf_pkg::OFF_SD_CMD) | hit(paddr_i, ptf_pkg::OFF_PHY_CTRL);
   assign pslverr_o = acc & ~mapped;

   // ------------------------------------------------
   // Control registers
   // ------------------------------------------------
   logic [15:0] gen_ctrl_q;
   logic [15:0] gen_cfg_q;
   logic [15:0] phy_ctrl_q;
   logic [1:0] rx_sel_q;
   logic [1:0] tx_sel_q;
   logic [24:0] sent_q;
   logic pass_thru;
   logic gen_en;
   logic gen_tx;
   logic limit_hit;
   assign pass_thru = phy_ctrl_q[ptf_pkg::PASS_BIT];
   assign gen_en = gen_ctrl_q[ptf_pkg::GEN_EN_BIT] & ~pass_thru;
   assign gen_tx = gen_en & gen_ctrl_q[ptf_pkg::GEN_TX_BIT];
   assign limit_hit = gen_tx & gen_frame_done_i & ~gen_ctrl_q[ptf_pkg::GEN_DUR_BIT]
      & (sent_q == ptf_pkg::FRAME_LIMIT - 25'h1);

   // Generator control with self-clearing transmit bit
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         gen_ctrl_q <= ptf_pkg::GEN_CTRL_RST;
      end else if (wr && hit(paddr_i, ptf_pkg::OFF_GEN_CTRL)) begin
         gen_ctrl_q <= pwdata_i[15:0];
      end else if (limit_hit) begin
         gen_ctrl_q[ptf_pkg::GEN_TX_BIT] <= 1'b0;
      end
   end

   // Frame count toward the duration limit
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !gen_tx || limit_hit) begin
         sent_q <= 25'h0;
      end else if (gen_frame_done_i) begin
         sent_q <= sent_q + 25'h1;
      end
   end

   // Settings and plain control words
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         gen_cfg_q <= 16'h0000;
         phy_ctrl_q <= 16'h0000;
         rx_sel_q <= ptf_pkg::SEL_MEDIA;
         tx_sel_q <= ptf_pkg::SEL_MEDIA;
      end else if (wr) begin
         if (hit(paddr_i, ptf_pkg::OFF_GEN_CFG)) gen_cfg_q <= pwdata_i[15:0];
         if (hit(paddr_i, ptf_pkg::OFF_PHY_CTRL)) phy_ctrl_q <= pwdata_i[15:0];
         if (hit(paddr_i, ptf_pkg::OFF_RX_SEL)) rx_sel_q <= pwdata_i[15:14];
         if (hit(paddr_i, ptf_pkg::OFF_TX_SEL)) tx_sel_q <= pwdata_i[15:14];
      end
   end

   // Datapath control outputs
   assign gen_active_o = gen_en;
   assign gen_sending_o = gen_tx;
   assign far_loop_o = phy_ctrl_q[ptf_pkg::FAR_BIT];
   assign near_loop_o = phy_ctrl_q[ptf_pkg::NEAR_BIT];
   assign mac_tx_ignore_o = gen_en | far_loop_o;
   assign mac_rx_enable_o = ~phy_ctrl_q[ptf_pkg::ISO_BIT];
   assign conn_loop_o = phy_ctrl_q[ptf_pkg::CONN_BIT];
   assign swap_off_o = phy_ctrl_q[ptf_pkg::SWAP_BIT] & conn_loop_o;

   // ------------------------------------------------
   // Counter sources
   // ------------------------------------------------
   logic [3:0] ev;
   logic [3:0] ok;
   logic [3:0] clr;
   // Point 0 copper, 1 receive select, 2 transmit select
   assign ev[0] = cu_rx_frame_i;
   assign ok[0] = cu_rx_crc_ok_i;
   assign ev[1] = (rx_sel_q == ptf_pkg::SEL_MAC) ? mac_rx_frame_i :
      (rx_sel_q == ptf_pkg::SEL_MEDIA) ? fib_rx_frame_i : 1'b0;
   assign ok[1] = (rx_sel_q == ptf_pkg::SEL_MAC) ? mac_rx_crc_ok_i : fib_rx_crc_ok_i;
   assign ev[2] = (tx_sel_q == ptf_pkg::SEL_MAC) ? mac_tx_frame_i :
      (tx_sel_q == ptf_pkg::SEL_MEDIA) ? fib_tx_frame_i : 1'b0;
   assign ok[2] = (tx_sel_q == ptf_pkg::SEL_MAC) ? mac_tx_crc_ok_i : fib_tx_crc_ok_i;
   assign ev[3] = 1'b0;
   assign ok[3] = 1'b0;
   // Good-register read clears flag and good count; bad read clears bad count
   logic [3:0] clr_bad;
   assign clr[0] = rd & hit(paddr_i, ptf_pkg::OFF_CU_GOOD);
   assign clr[1] = rd & hit(paddr_i, ptf_pkg::OFF_RX_GOOD);
   assign clr[2] = rd & hit(paddr_i, ptf_pkg::OFF_TX_GOOD);
   assign clr[3] = 1'b0;
   assign clr_bad[0] = rd & hit(paddr_i, ptf_pkg::OFF_CU_BAD);
   assign clr_bad[1] = rd & hit(paddr_i, ptf_pkg::OFF_RX_SEL);
   assign clr_bad[2] = rd & hit(paddr_i, ptf_pkg::OFF_TX_SEL);
   assign clr_bad[3] = 1'b0;

   logic [13:0] good_q [0:2];
   logic [7:0] bad_q [0:2];
   logic [2:0] flag_q;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_cnt
         logic [13:0] good_base;
         logic [7:0] bad_base;
         logic [13:0] good_d;
         logic [7:0] bad_d;
         // A frame in the read cycle counts from zero, so it survives the clear
         assign good_base = clr[g] ? 14'h0 : good_q[g];
         assign bad_base = clr_bad[g] ? 8'h0 : bad_q[g];
         assign good_d = (good_base == ptf_pkg::GOOD_MAX) ? 14'h0 : good_base + 14'h1;
         assign bad_d = (bad_base == ptf_pkg::BAD_MAX) ? bad_base : bad_base + 8'h1;
         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               good_q[g] <= 14'h0;
               bad_q[g] <= 8'h0;
               flag_q[g] <= 1'b0;
            end else begin
               flag_q[g] <= ev[g] | (flag_q[g] & ~clr[g]);
               good_q[g] <= (ev[g] & ok[g]) ? good_d : good_base;
               bad_q[g] <= (ev[g] & ~ok[g]) ? bad_d : bad_base;
            end
         end
      end
   endgenerate

   // ------------------------------------------------
   // SerDes loop command
   // ------------------------------------------------
   typedef enum logic [1:0] {
      SD_IDLE = 2'b00,
      SD_APPLY = 2'b01,
      SD_WAIT = 2'b10
   } ptf_sd_t;
   ptf_sd_t sd_q;
   logic [15:0] sd_cmd_q;
   logic [2:0] sd_cnt_q;
   logic sd_wr;
   logic sd_valid;
   assign sd_wr = wr & hit(paddr_i, ptf_pkg::OFF_SD_CMD) & (sd_q == SD_IDLE);
   assign sd_valid = (pwdata_i[15:12] == ptf_pkg::SD_TAG) & (pwdata_i[3:0] == ptf_pkg::SD_TAIL)
      & (pwdata_i[11:10] == 2'b00);

   // Accept a well-formed command and run it to completion
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sd_q <= SD_IDLE;
         sd_cmd_q <= 16'h0000;
         sd_cnt_q <= 3'h0;
         sd_port_o <= 4'h0;
         sd_loop_o <= ptf_pkg::LOOP_NONE;
      end else begin
         case (sd_q)
            SD_IDLE: begin
               if (sd_wr) begin
                  sd_cmd_q <= pwdata_i[15:0];
                  if (sd_valid) begin
                     sd_q <= SD_APPLY;
                     sd_port_o <= pwdata_i[11:8];
                     sd_loop_o <= loop_dec(pwdata_i[7:4]);
                     sd_cnt_q <= ptf_pkg::SD_APPLY_CYC;
                  end else begin
                     sd_cmd_q[15] <= 1'b0;
                  end
               end
            end
            SD_APPLY: begin
               sd_cnt_q <= sd_cnt_q - 3'h1;
               if (sd_cnt_q == 3'h1) sd_q <= SD_WAIT;
            end
            SD_WAIT: begin
               if (sd_done_i) begin
                  sd_cmd_q[15] <= 1'b0;
                  sd_q <= SD_IDLE;
               end
            end
            default: sd_q <= SD_IDLE;
         endcase
      end
   end
   assign sd_apply_o = (sd_q == SD_APPLY);

   // ------------------------------------------------
   // Read data
   // ------------------------------------------------
   logic [31:0] rdata_d;
   always_comb begin
      rdata_d = 32'h0;
      if (hit(paddr_i, ptf_pkg::OFF_GEN_CTRL)) rdata_d[15:0] = gen_ctrl_q;
      if (hit(paddr_i, ptf_pkg::OFF_GEN_CFG)) rdata_d[15:0] = gen_cfg_q;
      if (hit(paddr_i, ptf_pkg::OFF_CU_GOOD)) rdata_d[15:0] = {flag_q[0], 1'b0, good_q[0]};
      if (hit(paddr_i, ptf_pkg::OFF_CU_BAD)) rdata_d[15:0] = {8'h00, bad_q[0]};
      if (hit(paddr_i, ptf_pkg::OFF_RX_GOOD)) rdata_d[15:0] = {flag_q[1], 1'b0, good_q[1]};
      if (hit(paddr_i, ptf_pkg::OFF_RX_SEL)) rdata_d[15:0] = {rx_sel_q, 6'h00, bad_q[1]};
      if (hit(paddr_i, ptf_pkg::OFF_TX_GOOD)) rdata_d[15:0] = {flag_q[2], 1'b0, good_q[2]};
      if (hit(paddr_i, ptf_pkg::OFF_TX_SEL)) rdata_d[15:0] = {tx_sel_q, 6'h00, bad_q[2]};
      if (hit(paddr_i, ptf_pkg::OFF_SD_CMD)) rdata_d[15:0] = sd_cmd_q;
      if (hit(paddr_i, ptf_pkg::OFF_PHY_CTRL)) rdata_d[15:0] = phy_ctrl_q;
   end
   // Registered read data, loaded in the setup cycle
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) prdata_o <= 32'h0;
      else if (psel_i && !penable_i && !pwrite_i) prdata_o <= rdata_d;
   end
endmodule : ptf_top
`default_nettype wire

// ==== tb/ptf_mac_model.sv ====
// Far-side model: frame engine and SerDes completion
`timescale 1ns/1ps
`default_nettype none
module ptf_mac_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Controls from the block and the testbench
   input wire logic slow_i,
   input wire logic gen_sending_i,
   input wire logic sd_apply_i,
   // Answers to the block
   output logic gen_frame_done_o,
   output logic sd_done_o
);
   logic apply_q;
   logic [1:0] gap_q;
   logic [3:0] wait_q;
   // Frame every fourth cycle while sending; SerDes done after a prompt or slow delay
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         apply_q <= 1'b0;
         gap_q <= 2'h0;
         wait_q <= 4'h0;
         gen_frame_done_o <= 1'b0;
         sd_done_o <= 1'b0;
      end else begin
         apply_q <= sd_apply_i;
         gap_q <= gen_sending_i ? gap_q + 2'h1 : 2'h0;
         gen_frame_done_o <= gen_sending_i && gap_q == 2'h3;
         sd_done_o <= wait_q == 4'h1;
         if (apply_q && !sd_apply_i) wait_q <= slow_i ? 4'h6 : 4'h1;
         else if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
      end
   end
endmodule : ptf_mac_model
`default_nettype wire

// ==== tb/ptf_top_properties.sv ====
// Concurrent checks on the ports of the PHY test features block
`timescale 1ns/1ps
`default_nettype none
module ptf_top_properties (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic psel_i, penable_i, pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   // Datapath selects and SerDes control
   input wire logic gen_active_o, gen_sending_o, mac_tx_ignore_o, mac_rx_enable_o,
   input wire logic far_loop_o, near_loop_o, conn_loop_o, swap_off_o, sd_apply_o,
   input wire logic [3:0] sd_port_o,
   input wire logic [1:0] sd_loop_o
);
   // Register writes taken at the access edge
   wire logic wr_any = psel_i && penable_i && pwrite_i;
   wire logic wr_gen = wr_any && paddr_i == ptf_pkg::OFF_GEN_CTRL;
   wire logic wr_phy = wr_any && paddr_i == ptf_pkg::OFF_PHY_CTRL;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Generator, isolate and loop controls
   a_gen_off: assert property (wr_gen && !pwdata_i[15] |=> !gen_active_o && !gen_sending_o)
      else $error("generator still active after disable");
   a_gen_replace: assert property (gen_active_o |-> mac_tx_ignore_o)
      else $error("mac transmit not ignored in generator mode");
   a_rx_isolate: assert property (wr_phy |=> mac_rx_enable_o == !$past(pwdata_i[10]))
      else $error("receive enable does not follow isolate bit");
   a_send_needs: assert property (gen_sending_o |-> gen_active_o)
      else $error("sending without generator mode");
   a_pass_block: assert property (wr_phy && pwdata_i[8] |=> !gen_active_o)
      else $error("generator active in pass-through");
   a_far_loop: assert property (wr_phy |=> far_loop_o == $past(pwdata_i[3]) && (!far_loop_o || mac_tx_ignore_o))
      else $error("far loop control wrong");
   a_near_loop: assert property (wr_phy |=> near_loop_o == $past(pwdata_i[14]))
      else $error("near loop control wrong");
   a_swap_conn: assert property (swap_off_o |-> conn_loop_o)
      else $error("swap off without connector loop");
   a_apply_len: assert property ($rose(sd_apply_o) |-> sd_apply_o [*4] ##1 !sd_apply_o)
      else $error("apply pulse length wrong");
   a_sd_fields: assert property ($rose(sd_apply_o) |-> sd_port_o == $past(pwdata_i[11:8]) && sd_port_o < 4'h4
      && $past(pwdata_i[15:12]) == 4'h9 && $past(pwdata_i[3:0]) == 4'h2)
      else $error("serdes command fields wrong");
   a_sd_type: assert property ($rose(sd_apply_o) |-> sd_loop_o == ($past(pwdata_i[7:4]) == 4'h2 ? 2'h1 :
      $past(pwdata_i[7:4]) == 4'h4 ? 2'h2 : $past(pwdata_i[7:4]) == 4'h8 ? 2'h3 : 2'h0))
      else $error("loop type decode wrong");
endmodule : ptf_top_properties
bind ptf_top ptf_top_properties chk_i (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking testbench for the PHY test features block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, rst, psel, penable, pwrite, slow, err, gfd, sd_done, b;
   logic pready, pslverr, gen_active, gen_sending, ign, rxen, far, near, conn, swap, sd_apply;
   logic [11:0] paddr, a;
   logic [31:0] pwdata, prdata, r, d;
   logic [3:0] sd_port;
   logic [1:0] sd_loop, s;
   logic [4:0] fr, ok;
   logic [7:0] o;
   logic [39:0] tab [9] = '{40'h8000_0000_B0, 40'hE000_0000_F0, 40'hE000_0100_10, 40'h8000_0400_A0,
      40'h0000_0008_38, 40'h0000_4000_14, 40'h0000_0001_12, 40'h0000_0021_13, 40'h0000_0020_10};
   int mismatches, checked, seed, g, n, pt, k;
   assign o = {gen_active, gen_sending, ign, rxen, far, near, conn, swap};
   ptf_top dut (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .cu_rx_frame_i(fr[0]), .cu_rx_crc_ok_i(ok[0]), .fib_rx_frame_i(fr[1]), .fib_rx_crc_ok_i(ok[1]),
      .mac_rx_frame_i(fr[2]), .mac_rx_crc_ok_i(ok[2]), .fib_tx_frame_i(fr[3]), .fib_tx_crc_ok_i(ok[3]),
      .mac_tx_frame_i(fr[4]), .mac_tx_crc_ok_i(ok[4]), .gen_frame_done_i(gfd), .gen_active_o(gen_active),
      .gen_sending_o(gen_sending), .mac_tx_ignore_o(ign), .mac_rx_enable_o(rxen), .far_loop_o(far),
      .near_loop_o(near), .conn_loop_o(conn), .swap_off_o(swap), .sd_port_o(sd_port), .sd_loop_o(sd_loop),
      .sd_apply_o(sd_apply), .sd_done_i(sd_done));
   ptf_mac_model mac (.ref_clk_i(clk), .rst_i(rst), .slow_i(slow), .gen_sending_i(gen_sending),
      .sd_apply_i(sd_apply), .gen_frame_done_o(gfd), .sd_done_o(sd_done));
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #5000000;
      mismatches++;
      finish_test();
   end
   // Verdict
   task automatic finish_test;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer: setup, then access until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      int t;
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, ad, wd};
      @(posedge clk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      r = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      if (pready !== 1'b1) begin
         mismatches++;
         finish_test();
      end
      @(posedge clk);
   endtask : apb
   task automatic rd(input logic [11:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      chk(r, e);
   endtask : rd
   // Frame pulses at one point; mode 0 bad, 1 good, 2 random
   task automatic frames(input int p, input int cnt, input int mode);
      g = 0;
      repeat (cnt) begin
         b = mode == 2 ? 1'($random(seed)) : mode == 1;
         fr[p] <= 1'b1;
         ok[p] <= b;
         g += b;
         @(posedge clk);
      end
      fr[p] <= 1'b0;
      @(posedge clk);
   endtask : frames
   function automatic logic [31:0] good_exp(input int c);
      return {16'h0, c > 0, 1'b0, 14'(c % 10000)};
   endfunction : good_exp
   function automatic logic [31:0] bad_exp(input logic [1:0] sl, input int c);
      return {16'h0, sl, 6'h0, 8'(c > 255 ? 255 : c)};
   endfunction : bad_exp
   // Main sequence
   initial begin
      seed = 32'hD83F467E;
      {rst, psel, penable, pwrite, slow, paddr, pwdata, fr, ok} = '0;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (k = 0; k < 40; k += 4) rd(12'(k), 32'h0);
      chk({24'h0, o}, 32'h10);
      apb(1'b0, 12'h028, 32'h0);
      chk(r | {31'h0, ~err}, 32'h0);
      for (pt = 0; pt < 10; pt++) begin
         s = (pt % 5 == 2 || pt % 5 == 4) ? 2'h1 : 2'h0;
         a = pt % 5 == 0 ? ptf_pkg::OFF_CU_GOOD : pt % 5 < 3 ? ptf_pkg::OFF_RX_GOOD : ptf_pkg::OFF_TX_GOOD;
         if (pt % 5 > 0) begin
            apb(1'b1, a + 12'h4, {16'h0, s, 14'h0});
            frames(pt % 5 == 1 || pt % 5 == 3 ? pt % 5 + 1 : pt % 5 - 1, 3, 1);
         end
         n = 1 + $unsigned($random(seed)) % 50;
         frames(pt % 5, n, 2);
         rd(a, good_exp(g) | 32'h8000);
         rd(a + 12'h4, bad_exp(s, n - g));
         rd(a, 32'h0);
      end
      frames(0, 10001, 1);
      rd(ptf_pkg::OFF_CU_GOOD, good_exp(10001));
      frames(0, 300, 0);
      rd(ptf_pkg::OFF_CU_BAD, bad_exp(2'h0, 300));
      rd(ptf_pkg::OFF_CU_GOOD, 32'h8000);
      frames(0, 2, 1);
      fork
         rd(ptf_pkg::OFF_CU_GOOD, 32'h8002);
         begin
            @(posedge clk);
            fr[0] <= 1'b1;
            @(posedge clk);
            fr[0] <= 1'b0;
         end
      join
      rd(ptf_pkg::OFF_CU_GOOD, 32'h8001);
      for (k = 0; k < 9; k++) begin
         apb(1'b1, ptf_pkg::OFF_GEN_CTRL, {16'h0, tab[k][39:24]});
         apb(1'b1, ptf_pkg::OFF_PHY_CTRL, {16'h0, tab[k][23:8]});
         chk({24'h0, o}, {24'h0, tab[k][7:0]});
         rd(ptf_pkg::OFF_GEN_CTRL, {16'h0, tab[k][39:24]});
      end
      // SerDes loops are only switched here, with no timestamp unit in the path
      for (k = 0; k < 5; k++) begin
         slow <= k[0];
         d = k < 4 ? {16'h0, 4'h9, 4'($random(seed) & 3), 4'(k == 0 ? 0 : 1 << k), 4'h2} : 32'h8142;
         apb(1'b1, ptf_pkg::OFF_SD_CMD, d);
         if (k < 4) chk({26'h0, sd_port, sd_loop}, {26'h0, d[11:8], 2'(k)});
         for (n = 0; n < 20; n++) begin
            apb(1'b0, ptf_pkg::OFF_SD_CMD, 32'h0);
            if (r[15] === 1'b0) break;
         end
         chk(r, d & 32'h7FFF);
      end
      finish_test();
   end
endmodule : testbench
`default_nettype wire
